/* hdl/pcireg_bank.sv */
// Identification and command/status registers of the first PCI port.
// Assumes PCI and processor bus register ports are on CORE_CLK; resets and
// power-up options are asynchronous pins and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module pcireg_bank (
    // Clock and resets
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic PROC_BUS_RESET_N,
    input wire logic PCI_A_RESET_N,
    input wire logic PCI_B_RESET_N,
    output logic GENERAL_RESET_N,
    // PCI side register port
    input wire logic PCI_REQ,
    input wire logic PCI_WR,
    input wire logic [11:0] PCI_ADDR,
    input wire logic [3:0] PCI_BE,
    input wire logic [31:0] PCI_WDATA,
    output logic [31:0] PCI_RDATA,
    // Processor bus register port, big-endian numbering
    input wire logic PB_REQ,
    input wire logic PB_WR,
    input wire logic [11:0] PB_ADDR,
    input wire logic [3:0] PB_BE,
    input wire logic [31:0] PB_WDATA,
    output logic [31:0] PB_RDATA,
    // EEPROM load of loadable fields
    input wire logic EE_LOAD,
    input wire logic [15:0] EE_DEV_IDENT,
    input wire logic [15:0] EE_VEN_IDENT,
    input wire logic EE_BUS_MASTER,
    input wire logic EE_MEM_SPACE,
    // Power-up option
    input wire logic POWER_UP_PRIMARY,
    // Error events from master and target modules
    input wire logic MASTER_DATA_PERR,
    input wire logic TARGET_DATA_PERR,
    input wire logic TARGET_ADDR_PERR,
    input wire logic MASTER_ABORT,
    input wire logic TARGET_ABORT_RCVD,
    // Outputs
    output logic SYSTEM_ERROR_N,
    output logic BUS_MASTER_EN,
    output logic MEM_SPACE_EN
);
    logic [1:0] gen_sync, pa_sync, strap_sync;
    logic pa_rst_n, gen_rst_n;
    logic [15:0] dev_ident, ven_ident;
    logic sys_err_en, par_resp, bus_master, mem_space, cap_list;
    logic flag_pe, flag_se, flag_ma, flag_ta;
    logic strap_taken;
    // Combine resets asynchronously, release synchronously
    assign gen_rst_n = ARST_N & PROC_BUS_RESET_N & PCI_A_RESET_N & PCI_B_RESET_N;
    always_ff @(posedge CORE_CLK or negedge gen_rst_n) begin
        if (!gen_rst_n) begin
            gen_sync <= 2'h0;
        end else begin
            gen_sync <= {gen_sync[0], 1'b1};
        end
    end
    assign GENERAL_RESET_N = gen_sync[1];
    wire pa_async_n = ARST_N & PCI_A_RESET_N;
    always_ff @(posedge CORE_CLK or negedge pa_async_n) begin
        if (!pa_async_n) begin
            pa_sync <= 2'h0;
        end else begin
            pa_sync <= {pa_sync[0], 1'b1};
        end
    end
    assign pa_rst_n = pa_sync[1];
    // Strap synchroniser runs free, so it is already settled when port reset lifts
    always_ff @(posedge CORE_CLK) begin
        strap_sync <= {strap_sync[0], POWER_UP_PRIMARY};
    end
    // Strap caught once, at the first edge after release
    always_ff @(posedge CORE_CLK or negedge pa_rst_n) begin
        if (!pa_rst_n) begin
            strap_taken <= 1'b0;
            cap_list <= 1'b0;
        end else begin
            strap_taken <= 1'b1;
            if (!strap_taken) begin
                cap_list <= strap_sync[1];
            end
        end
    end
    // Processor bus bit order is reversed, bit 0 to bit 31, for big-endian numbering
    function automatic logic [31:0] bitrev(input logic [31:0] v);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 32; i++) begin
            r[i] = v[31 - i];
        end
        return r;
    endfunction
    wire [31:0] pb_wdata_le = bitrev(PB_WDATA);
    wire [3:0] pb_be_le = {PB_BE[0], PB_BE[1], PB_BE[2], PB_BE[3]};
    wire [31:0] pb_mask = {{8{pb_be_le[3]}}, {8{pb_be_le[2]}}, {8{pb_be_le[1]}}, {8{pb_be_le[0]}}};
    wire [31:0] pci_mask = {{8{PCI_BE[3]}}, {8{PCI_BE[2]}}, {8{PCI_BE[1]}}, {8{PCI_BE[0]}}};
    wire pb_id_wr = PB_REQ & PB_WR & (PB_ADDR == pcireg_pkg::OFS_IDENT);
    wire pb_cs_wr = PB_REQ & PB_WR & (PB_ADDR == pcireg_pkg::OFS_CMDSTAT);
    wire pci_cs_wr = PCI_REQ & PCI_WR & (PCI_ADDR == pcireg_pkg::OFS_CMDSTAT);
    // PCI writes to identification are dropped here, not decoded at all
    wire [31:0] cs_wval = pb_cs_wr ? (pb_wdata_le & pb_mask) : (PCI_WDATA & pci_mask);
    wire cs_wr = pb_cs_wr | pci_cs_wr;
    wire [31:0] id_cur = {dev_ident, ven_ident};
    wire [31:0] id_next = (id_cur & ~pb_mask) | (pb_wdata_le & pb_mask);
    always_ff @(posedge CORE_CLK or negedge pa_rst_n) begin
        if (!pa_rst_n) begin
            dev_ident <= pcireg_pkg::DEV_IDENT_DFLT;
            ven_ident <= pcireg_pkg::VEN_IDENT_DFLT;
            sys_err_en <= 1'b0;
            par_resp <= 1'b0;
            bus_master <= 1'b0;
            mem_space <= 1'b0;
        end else if (EE_LOAD) begin
            dev_ident <= EE_DEV_IDENT;
            ven_ident <= EE_VEN_IDENT;
            bus_master <= EE_BUS_MASTER;
            mem_space <= EE_MEM_SPACE;
        end else begin
            if (pb_id_wr) begin
                dev_ident <= id_next[31:16];
                ven_ident <= id_next[15:0];
            end
            if (cs_wr) begin
                if (pb_cs_wr ? pb_mask[pcireg_pkg::SYS_ERR_EN_BIT] : pci_mask[pcireg_pkg::SYS_ERR_EN_BIT])
                    sys_err_en <= cs_wval[pcireg_pkg::SYS_ERR_EN_BIT];
                if (pb_cs_wr ? pb_mask[pcireg_pkg::PAR_RESP_BIT] : pci_mask[pcireg_pkg::PAR_RESP_BIT]) begin
                    par_resp <= cs_wval[pcireg_pkg::PAR_RESP_BIT];
                    bus_master <= cs_wval[pcireg_pkg::BUS_MASTER_BIT];
                    mem_space <= cs_wval[pcireg_pkg::MEM_SPACE_BIT];
                end
            end
        end
    end
    // Error events
    wire set_pe = MASTER_DATA_PERR | TARGET_DATA_PERR | TARGET_ADDR_PERR;
    wire serr_fire = TARGET_ADDR_PERR & sys_err_en & par_resp;
    pcireg_flag u_pe (.clk(CORE_CLK), .rst_n(pa_rst_n), .set(set_pe),
        .clr(cs_wr & cs_wval[pcireg_pkg::PARITY_DET_BIT]), .flag(flag_pe));
    pcireg_flag u_se (.clk(CORE_CLK), .rst_n(pa_rst_n), .set(serr_fire),
        .clr(cs_wr & cs_wval[pcireg_pkg::SYS_ERR_SIG_BIT]), .flag(flag_se));
    pcireg_flag u_ma (.clk(CORE_CLK), .rst_n(pa_rst_n), .set(MASTER_ABORT),
        .clr(cs_wr & cs_wval[pcireg_pkg::MASTER_ABT_BIT]), .flag(flag_ma));
    pcireg_flag u_ta (.clk(CORE_CLK), .rst_n(pa_rst_n), .set(TARGET_ABORT_RCVD),
        .clr(cs_wr & cs_wval[pcireg_pkg::TARGET_ABT_BIT]), .flag(flag_ta));
    always_ff @(posedge CORE_CLK or negedge pa_rst_n) begin
        if (!pa_rst_n) begin
            SYSTEM_ERROR_N <= 1'b1;
        end else begin
            SYSTEM_ERROR_N <= ~serr_fire;
        end
    end
    assign BUS_MASTER_EN = bus_master;
    assign MEM_SPACE_EN = mem_space;
    // Reserved and unimplemented bits read zero
    logic [31:0] cs_val;
    always_comb begin
        cs_val = 32'h0;
        cs_val[pcireg_pkg::PARITY_DET_BIT] = flag_pe;
        cs_val[pcireg_pkg::SYS_ERR_SIG_BIT] = flag_se;
        cs_val[pcireg_pkg::MASTER_ABT_BIT] = flag_ma;
        cs_val[pcireg_pkg::TARGET_ABT_BIT] = flag_ta;
        cs_val[pcireg_pkg::DEVSEL_LO_BIT +: 2] = pcireg_pkg::DEVSEL_TIMING;
        cs_val[pcireg_pkg::DEV66_BIT] = 1'b1;
        cs_val[pcireg_pkg::CAP_LIST_BIT] = cap_list;
        cs_val[pcireg_pkg::SYS_ERR_EN_BIT] = sys_err_en;
        cs_val[pcireg_pkg::PAR_RESP_BIT] = par_resp;
        cs_val[pcireg_pkg::BUS_MASTER_BIT] = bus_master;
        cs_val[pcireg_pkg::MEM_SPACE_BIT] = mem_space;
    end
    // No write-one-to-set fields live here; any would read as zero
    wire [31:0] pci_sel = (PCI_ADDR == pcireg_pkg::OFS_IDENT) ? id_cur :
        (PCI_ADDR == pcireg_pkg::OFS_CMDSTAT) ? cs_val : 32'h0;
    wire [31:0] pb_sel = (PB_ADDR == pcireg_pkg::OFS_IDENT) ? id_cur :
        (PB_ADDR == pcireg_pkg::OFS_CMDSTAT) ? cs_val : 32'h0;
    always_ff @(posedge CORE_CLK or negedge pa_rst_n) begin
        if (!pa_rst_n) begin
            PCI_RDATA <= 32'h0;
            PB_RDATA <= 32'h0;
        end else begin
            if (PCI_REQ && !PCI_WR)
                PCI_RDATA <= pci_sel;
            if (PB_REQ && !PB_WR)
                PB_RDATA <= bitrev(pb_sel);
        end
    end
    a_pci_id_ro: assert property (@(posedge CORE_CLK) disable iff (!pa_rst_n)
        (!pb_id_wr && !EE_LOAD) |=> $stable(dev_ident) && $stable(ven_ident))
        else $error("identification changed without proc bus write");
    a_serr_gate: assert property (@(posedge CORE_CLK) disable iff (!pa_rst_n)
        !SYSTEM_ERROR_N |-> $past(sys_err_en && par_resp))
        else $error("system error without both enables");
    a_parity_set: assert property (@(posedge CORE_CLK) disable iff (!pa_rst_n)
        set_pe |=> flag_pe)
        else $error("parity flag not set");
    a_abort_set: assert property (@(posedge CORE_CLK) disable iff (!pa_rst_n)
        MASTER_ABORT |=> flag_ma)
        else $error("master abort flag not set");
    a_tabort_set: assert property (@(posedge CORE_CLK) disable iff (!pa_rst_n)
        TARGET_ABORT_RCVD |=> flag_ta)
        else $error("target abort flag not set");
    a_gen_reset: assert property (@(posedge CORE_CLK)
        !PCI_B_RESET_N |=> !GENERAL_RESET_N)
        else $error("general reset missed");
    a_pb_endian: assert property (@(posedge CORE_CLK) disable iff (!pa_rst_n)
        (PB_REQ && !PB_WR && PB_ADDR == pcireg_pkg::OFS_CMDSTAT) |=> PB_RDATA[0] == $past(flag_pe))
        else $error("proc bus bit order wrong");
    a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!pa_rst_n)
        (PCI_REQ && !PCI_WR && PCI_ADDR == pcireg_pkg::OFS_CMDSTAT) |=> PCI_RDATA[15:9] == 7'h0)
        else $error("reserved bits not zero");
    c_serr: cover property (@(posedge CORE_CLK) disable iff (!pa_rst_n) !SYSTEM_ERROR_N);
    c_id_wr: cover property (@(posedge CORE_CLK) disable iff (!pa_rst_n) pb_id_wr);
    c_clear: cover property (@(posedge CORE_CLK) disable iff (!pa_rst_n) flag_pe ##1 !flag_pe);
endmodule
`default_nettype wire

/* hdl/pcireg_flag.sv */
// Sticky error flag: set by hardware, cleared by writing one.
// Assumes set and clear are single-cycle strobes on CORE_CLK.
`timescale 1ns/10ps
`default_nettype none
module pcireg_flag (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Events
    input wire logic set,
    input wire logic clr,
    // State
    output logic flag
);
    logic next_flag;
    // Set beats a simultaneous clear so no event is lost
    assign next_flag = set | (flag & ~clr);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        set |=> flag)
        else $error("flag not set after event");
    a_clear_only_one: assert property (@(posedge clk) disable iff (!rst_n)
        (flag && !clr) |=> flag)
        else $error("flag dropped without clear");
endmodule
`default_nettype wire

/* hdl/pcireg_pkg.sv */
// Package for the first PCI port identification and status register bank.
// Assumes both register ports are synchronous to CORE_CLK.
package pcireg_pkg;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_IDENT = 12'h000;
    localparam logic [11:0] OFS_CMDSTAT = 12'h004;
    // Identity defaults, arbitrary neutral values
    localparam logic [15:0] DEV_IDENT_DFLT = 16'h0a5a;
    localparam logic [15:0] VEN_IDENT_DFLT = 16'h0c3c;
    // Command/status field positions, little-endian bit numbering
    localparam int PARITY_DET_BIT = 31;
    localparam int SYS_ERR_SIG_BIT = 30;
    localparam int MASTER_ABT_BIT = 29;
    localparam int TARGET_ABT_BIT = 28;
    localparam int SYS_ERR_EN_BIT = 8;
    localparam int PAR_RESP_BIT = 6;
    localparam int CAP_LIST_BIT = 20;
    localparam int DEV66_BIT = 21;
    localparam int BUS_MASTER_BIT = 2;
    localparam int MEM_SPACE_BIT = 1;
    localparam int DEVSEL_LO_BIT = 25;
    localparam logic [1:0] DEVSEL_TIMING = 2'h1;
    // Loader handshake states
    typedef enum logic [1:0] {
        PCIREG_LOAD_IDLE = 2'b00,
        PCIREG_LOAD_BUSY = 2'b01,
        PCIREG_LOAD_DONE = 2'b10
    } pcireg_load_t;
endpackage

/* verif/pcireg_evt_model.sv */
// Model of the master and target modules raising error events.
// Assumes bench requests on CORE_CLK; each rise gives one pulse.
`timescale 1ns/10ps
`default_nettype none
module pcireg_evt_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request per event kind, and the pulses
    input wire logic [4:0] req,
    output logic [4:0] pulse
);
    logic [4:0] prev;
    // Edge detect, so a held request never repeats the event
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 5'h00;
            pulse <= 5'h00;
        end else begin
            prev <= req;
            pulse <= req & ~prev;
        end
    end
endmodule
`default_nettype wire

/* verif/tb_pci_port_id_and_status_regs.sv */
// Self-checking bench for the first PCI port register bank.
// Assumes the bank and the event model, all on CORE_CLK.
`timescale 1ns/10ps
`default_nettype none
module tb_pci_port_id_and_status_regs;
    typedef struct packed {
        logic [1:0] op;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wd;
        logic [31:0] ex;
    } pcireg_row_t;
    // Op bit1 picks processor bus, bit0 a write; values in PCI numbering
    pcireg_row_t rows [14] = '{
        '{2'h0, 12'h000, 4'hf, 32'h0, 32'h0a5a0c3c},
        '{2'h0, 12'h004, 4'hf, 32'h0, 32'h02300000},
        '{2'h0, 12'h008, 4'hf, 32'h0, 32'h0},
        '{2'h1, 12'h000, 4'hf, 32'hffffffff, 32'h0},
        '{2'h0, 12'h000, 4'hf, 32'h0, 32'h0a5a0c3c},
        '{2'h3, 12'h000, 4'hf, 32'h12345678, 32'h0},
        '{2'h2, 12'h000, 4'hf, 32'h0, 32'h12345678},
        '{2'h0, 12'h000, 4'hf, 32'h0, 32'h12345678},
        '{2'h1, 12'h004, 4'hf, 32'h00000146, 32'h0},
        '{2'h2, 12'h004, 4'hf, 32'h0, 32'h02300146},
        '{2'h3, 12'h000, 4'h8, 32'haa000000, 32'h0},
        '{2'h0, 12'h000, 4'hf, 32'h0, 32'haa345678},
        '{2'h1, 12'h008, 4'hf, 32'hffffffff, 32'h0},
        '{2'h2, 12'h008, 4'hf, 32'h0, 32'h0}
    };
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic [2:0] rst3 = 3'h7;
    logic req [2] = '{1'h0, 1'h0};
    logic wr [2] = '{1'h0, 1'h0};
    logic [11:0] addr [2] = '{12'h0, 12'h0};
    logic [3:0] be [2] = '{4'h0, 4'h0};
    logic [31:0] wd [2] = '{32'h0, 32'h0};
    logic [31:0] rd [2];
    logic ee_load = 1'h0;
    logic [15:0] ee_dev = 16'h0;
    logic [15:0] ee_ven = 16'h0;
    logic ee_bm = 1'h0;
    logic ee_ms = 1'h0;
    logic pwr_pri = 1'h1;
    logic [4:0] ev = 5'h00;
    logic [4:0] pulse;
    logic gen_n, serr_n, bm_en, ms_en;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    pcireg_evt_model pcireg_evt_model_i (.clk(clk), .rst_n(arst_n), .req(ev), .pulse(pulse));

    pcireg_bank pcireg_bank_i (
        .CORE_CLK(clk), .ARST_N(arst_n), .PROC_BUS_RESET_N(rst3[0]), .PCI_B_RESET_N(rst3[1]),
        .PCI_A_RESET_N(rst3[2]), .GENERAL_RESET_N(gen_n),
        .PCI_REQ(req[0]), .PCI_WR(wr[0]), .PCI_ADDR(addr[0]), .PCI_BE(be[0]),
        .PCI_WDATA(wd[0]), .PCI_RDATA(rd[0]),
        .PB_REQ(req[1]), .PB_WR(wr[1]), .PB_ADDR(addr[1]), .PB_BE(be[1]),
        .PB_WDATA(wd[1]), .PB_RDATA(rd[1]),
        .EE_LOAD(ee_load), .EE_DEV_IDENT(ee_dev), .EE_VEN_IDENT(ee_ven),
        .EE_BUS_MASTER(ee_bm), .EE_MEM_SPACE(ee_ms), .POWER_UP_PRIMARY(pwr_pri),
        .MASTER_DATA_PERR(pulse[0]), .TARGET_DATA_PERR(pulse[1]), .TARGET_ADDR_PERR(pulse[2]),
        .MASTER_ABORT(pulse[3]), .TARGET_ABORT_RCVD(pulse[4]),
        .SYSTEM_ERROR_N(serr_n), .BUS_MASTER_EN(bm_en), .MEM_SPACE_EN(ms_en)
    );

    function automatic logic [31:0] rev(input logic [31:0] x);
        return {<<{x}};
    endfunction

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One request, taken at the second edge; read data settled one edge later
    task automatic acc(input logic [1:0] op, input logic [11:0] a, input logic [3:0] b,
                       input logic [31:0] d, output logic [31:0] q);
        int p;
        p = int'(op[1]);
        @(posedge clk);
        ev <= 5'h00;
        req[p] <= 1'h1;
        wr[p] <= op[0];
        addr[p] <= a;
        be[p] <= p ? {b[0], b[1], b[2], b[3]} : b;
        wd[p] <= p ? rev(d) : d;
        @(posedge clk);
        req[p] <= 1'h0;
        @(posedge clk);
        #1;
        q = p ? rev(rd[1]) : rd[0];
    endtask

    // Fire events and count cycles of the system error output low
    task automatic fire(input logic [4:0] m, output int seen);
        seen = 0;
        @(posedge clk);
        ev <= m;
        repeat (4) begin
            @(posedge clk);
            #1;
            if (serr_n === 1'h0) seen++;
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        logic [31:0] q;
        int seen;
        repeat (6) @(posedge clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            acc(rows[i].op, rows[i].addr, rows[i].be, rows[i].wd, q);
            if (!rows[i].op[0]) chk("row", q, rows[i].ex);
        end
        chk("enables", {30'h0, bm_en, ms_en}, 32'h3);
        fire(5'h04, seen);
        chk("serr_cycles", seen, 32'h1);
        acc(2'h0, 12'h004, 4'hf, 32'h0, q);
        chk("addr_perr", q, 32'hc2300146);
        fire(5'h18, seen);
        acc(2'h0, 12'h004, 4'hf, 32'h0, q);
        chk("aborts", q, 32'hf2300146);
        acc(2'h1, 12'h004, 4'hf, 32'hf0000146, q);
        acc(2'h0, 12'h004, 4'hf, 32'h0, q);
        chk("cleared", q, 32'h02300146);
        // Data parity event lands on the same edge as the clearing write
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            ev <= 5'(1 << i);
            acc(2'h1, 12'h004, 4'hf, 32'hf0000146, q);
            acc(2'h0, 12'h004, 4'hf, 32'h0, q);
            chk("set_wins", q, 32'h82300146);
            acc(2'h1, 12'h004, 4'hf, 32'hf0000146, q);
        end
        acc(2'h1, 12'h004, 4'hf, 32'h00000006, q);
        fire(5'h04, seen);
        chk("serr_masked", seen, 32'h0);
        @(posedge clk);
        {ee_dev, ee_ven, ee_bm, ee_ms} <= {16'h1111, 16'h2222, 1'h0, 1'h1};
        ee_load <= 1'h1;
        @(posedge clk);
        ee_load <= 1'h0;
        pwr_pri <= 1'h0;
        acc(2'h0, 12'h000, 4'hf, 32'h0, q);
        chk("ee_ident", q, 32'h11112222);
        chk("ee_enables", {30'h0, bm_en, ms_en}, 32'h1);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            rst3[k] <= 1'h0;
            repeat (2) @(posedge clk);
            #1;
            chk("gen_low", {31'h0, gen_n}, 32'h0);
            @(posedge clk);
            rst3[k] <= 1'h1;
            repeat (4) @(posedge clk);
            #1;
            chk("gen_high", {31'h0, gen_n}, 32'h1);
        end
        acc(2'h0, 12'h000, 4'hf, 32'h0, q);
        chk("ident_reset", q, 32'h0a5a0c3c);
        acc(2'h0, 12'h004, 4'hf, 32'h0, q);
        chk("status_reset", q, 32'h02200000);
        final_report();
    end
endmodule
`default_nettype wire
